// *** verilog/fraops_pkg.sv ***
package fraops_pkg;
    // instruction word layout
    localparam int WORD_W       = 14;
    localparam int DATA_W       = 8;
    localparam int ADDR_W       = 7;
    localparam int BITSEL_W     = 3;
    localparam int OPC_HI       = 13;
    localparam int OPC_LO       = 8;
    localparam int DEST_POS     = 7;
    localparam int BITSEL_HI    = 9;
    localparam int BITSEL_LO    = 7;
    localparam int BITOP_HI     = 13;
    localparam int BITOP_LO     = 10;
    // opcodes
    localparam logic [5:0] OPC_ADD_WORK_TO_FILE   = 6'h07;
    localparam logic [5:0] OPC_AND_WORK_WITH_FILE = 6'h05;
    localparam logic [3:0] OPC_BIT_CLEAR_FILE     = 4'h4;
    localparam logic [3:0] OPC_BIT_SET_FILE       = 4'h5;
    // status flag positions and reset values
    localparam int CARRY_POS    = 0;
    localparam int DIGIT_POS    = 1;
    localparam int ZERO_POS     = 2;
    localparam int NIBBLE_W     = 4;
    localparam logic [DATA_W-1:0] WORK_RST   = 8'h00;
    localparam logic [2:0]        STATUS_RST = 3'h0;

    typedef enum logic [2:0] {
        FRAOPS_OP_NONE,
        FRAOPS_OP_ADD,
        FRAOPS_OP_AND,
        FRAOPS_OP_BCLR,
        FRAOPS_OP_BSET
    } fraops_op_t;
endpackage

// *** verilog/fraops_decode.sv ***
// splits the instruction word into operation and operand fields
module fraops_decode (
    input  wire logic [13:0]        instr,    // instruction word
    output fraops_pkg::fraops_op_t  op,       // recognised operation
    output logic                    dest_f,   // destination is file register
    output logic [6:0]              faddr,    // file register address
    output logic [2:0]              bitsel    // bit number
);
    // only the four opcodes of this block are recognised; all else is none
    always_comb begin
        op = fraops_pkg::FRAOPS_OP_NONE;
        if (instr[fraops_pkg::OPC_HI:fraops_pkg::OPC_LO] == fraops_pkg::OPC_ADD_WORK_TO_FILE) begin
            op = fraops_pkg::FRAOPS_OP_ADD;
        end else if (instr[fraops_pkg::OPC_HI:fraops_pkg::OPC_LO] == fraops_pkg::OPC_AND_WORK_WITH_FILE) begin
            op = fraops_pkg::FRAOPS_OP_AND;
        end else if (instr[fraops_pkg::BITOP_HI:fraops_pkg::BITOP_LO] == fraops_pkg::OPC_BIT_CLEAR_FILE) begin
            op = fraops_pkg::FRAOPS_OP_BCLR;
        end else if (instr[fraops_pkg::BITOP_HI:fraops_pkg::BITOP_LO] == fraops_pkg::OPC_BIT_SET_FILE) begin
            op = fraops_pkg::FRAOPS_OP_BSET;
        end
    end

    assign dest_f = instr[fraops_pkg::DEST_POS];
    assign faddr  = instr[fraops_pkg::ADDR_W-1:0];
    assign bitsel = instr[fraops_pkg::BITSEL_HI:fraops_pkg::BITSEL_LO];
endmodule

// *** verilog/fraops_alu.sv ***
// combinational add / and / bit-modify unit with flag outputs
module fraops_alu (
    input  fraops_pkg::fraops_op_t  op,        // operation
    input  wire logic [7:0]         work,      // working register
    input  wire logic [7:0]         fval,      // file operand
    input  wire logic [2:0]         bitsel,    // bit number
    output logic [7:0]              result,    // result byte
    output logic                    carry,     // carry out of bit 7
    output logic                    digit,     // carry out of bit 3
    output logic                    zero       // result is zero
);
    logic [8:0] sum9;
    logic [4:0] low5;

    assign sum9 = {1'b0, work} + {1'b0, fval};
    assign low5 = {1'b0, work[fraops_pkg::NIBBLE_W-1:0]} + {1'b0, fval[fraops_pkg::NIBBLE_W-1:0]};

    // one result mux; flags are only consumed where the op allows
    always_comb begin
        result = fval;
        case (op)
            fraops_pkg::FRAOPS_OP_ADD:  result = sum9[7:0];
            fraops_pkg::FRAOPS_OP_AND:  result = work & fval;
            fraops_pkg::FRAOPS_OP_BCLR: result = fval & ~(8'h01 << bitsel);
            fraops_pkg::FRAOPS_OP_BSET: result = fval | (8'h01 << bitsel);
            default:                    result = fval;
        endcase
    end

    assign carry = sum9[8];
    assign digit = low5[4];
    assign zero  = (result == 8'h00);
endmodule

// *** verilog/fraops_core.sv ***
module fraops_core #(
    parameter logic [6:0] TIMER_ZERO_ADDR = 7'h01,   // address of timer zero count
    parameter int         NUM_PORTS       = 2,       // number of port registers
    parameter logic [6:0] PORT_BASE_ADDR  = 7'h05    // address of first port register
) (
    input  wire logic        sys_clk,          // instruction clock
    input  wire logic        rst_b,            // async reset, active low
    input  wire logic        instr_valid,      // instruction present this cycle
    input  wire logic [13:0] instr,            // instruction word
    input  wire logic [7:0]  file_rdata,       // file register contents at file_addr
    input  wire logic [NUM_PORTS*8-1:0] port_pins, // raw port pin levels
    input  wire logic        prescale_to_timer,// prescaler assigned to timer zero
    output logic [6:0]       file_addr,        // file register address
    output logic             file_we,          // file register write strobe
    output logic [7:0]       file_wdata,       // file register write data
    output logic [7:0]       work_q,           // working register
    output logic             carry_q,          // carry flag
    output logic             digit_carry_flag_q, // digit carry flag
    output logic             zero_q,           // zero flag
    output logic             prescale_clr,     // prescaler clear pulse
    output logic             instr_done        // instruction retired this cycle
);
    fraops_pkg::fraops_op_t op;
    logic                   dest_f;
    logic [2:0]             bitsel;
    logic [7:0]             operand;
    logic [7:0]             result;
    logic                   alu_carry;
    logic                   alu_digit;
    logic                   alu_zero;
    logic                   is_byte_op;
    logic                   writes_file;
    logic [NUM_PORTS*8-1:0] pins_meta_q;
    logic [NUM_PORTS*8-1:0] pins_sync_q;
    logic [NUM_PORTS-1:0]   port_hit;
    logic [7:0]             port_val [NUM_PORTS];

    fraops_decode u_decode (
        .instr  (instr),
        .op     (op),
        .dest_f (dest_f),
        .faddr  (file_addr),
        .bitsel (bitsel)
    );

    // pins come from outside the clock domain, so two flops first
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pins_meta_q <= '0;
            pins_sync_q <= '0;
        end else begin
            pins_meta_q <= port_pins;
            pins_sync_q <= pins_meta_q;
        end
    end

    // per-port address match and pin value
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
            assign port_hit[gi] = (file_addr == PORT_BASE_ADDR + 7'(gi));
            assign port_val[gi] = pins_sync_q[gi*8 +: 8];
        end
    endgenerate

    // port registers read back from their pins, not from the latch
    always_comb begin
        operand = file_rdata;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (port_hit[i]) begin
                operand = port_val[i];
            end
        end
    end

    fraops_alu u_alu (
        .op     (op),
        .work   (work_q),
        .fval   (operand),
        .bitsel (bitsel),
        .result (result),
        .carry  (alu_carry),
        .digit  (alu_digit),
        .zero   (alu_zero)
    );

    assign is_byte_op  = (op == fraops_pkg::FRAOPS_OP_ADD) || (op == fraops_pkg::FRAOPS_OP_AND);
    // bit ops always write the file; byte ops only with destination one
    assign writes_file = instr_valid && (op != fraops_pkg::FRAOPS_OP_NONE) &&
                         (!is_byte_op || dest_f);

    // write strobe is combinational so the file updates at the same edge as work
    assign file_we      = writes_file;
    assign file_wdata   = result;
    assign prescale_clr = writes_file && prescale_to_timer && (file_addr == TIMER_ZERO_ADDR);
    assign instr_done   = instr_valid;

    // working register takes byte-op results with destination zero
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            work_q <= fraops_pkg::WORK_RST;
        end else if (instr_valid && is_byte_op && !dest_f) begin
            work_q <= result;
        end
    end

    // status flags: add touches all three, and only zero, bit ops none
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            carry_q            <= fraops_pkg::STATUS_RST[fraops_pkg::CARRY_POS];
            digit_carry_flag_q <= fraops_pkg::STATUS_RST[fraops_pkg::DIGIT_POS];
            zero_q             <= fraops_pkg::STATUS_RST[fraops_pkg::ZERO_POS];
        end else if (instr_valid) begin
            if (op == fraops_pkg::FRAOPS_OP_ADD) begin
                carry_q            <= alu_carry;
                digit_carry_flag_q <= alu_digit;
                zero_q             <= alu_zero;
            end else if (op == fraops_pkg::FRAOPS_OP_AND) begin
                zero_q <= alu_zero;
            end
        end
    end

    // sum and nibble sum recomputed independently for checking
    logic [8:0] chk_sum;
    logic [4:0] chk_low;
    assign chk_sum = {1'b0, work_q} + {1'b0, operand};
    assign chk_low = {1'b0, work_q[fraops_pkg::NIBBLE_W-1:0]} + {1'b0, operand[fraops_pkg::NIBBLE_W-1:0]};

    a_add_flags: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (instr_valid && op == fraops_pkg::FRAOPS_OP_ADD) |=>
        (carry_q == $past(chk_sum[8]) && zero_q == ($past(chk_sum[7:0]) == 8'h00) &&
         digit_carry_flag_q == $past(chk_low[4])))
        else $error("add flags wrong");

    a_and_carry_keep: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (instr_valid && op == fraops_pkg::FRAOPS_OP_AND) |=>
        ($stable(carry_q) && $stable(digit_carry_flag_q) && zero_q == ($past(work_q & operand) == 8'h00)))
        else $error("and touched wrong flags");

    a_dest_work: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (instr_valid && is_byte_op && !dest_f) |-> (!file_we ##1 work_q == $past(result)))
        else $error("work destination wrong");

    a_dest_file: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (instr_valid && is_byte_op && dest_f) |-> (file_we && file_wdata == result) ##1 $stable(work_q))
        else $error("file destination wrong");

    a_bit_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (instr_valid && op == fraops_pkg::FRAOPS_OP_BCLR) |->
        (file_we && !file_wdata[bitsel] && ((file_wdata | (8'h01 << bitsel)) == (operand | (8'h01 << bitsel)))))
        else $error("bit clear wrong");

    a_bit_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (instr_valid && op == fraops_pkg::FRAOPS_OP_BSET) |->
        (file_we && file_wdata[bitsel] &&
         ((file_wdata & ~(8'h01 << bitsel)) == (operand & ~(8'h01 << bitsel)))) ##1
        ($stable(zero_q) && $stable(carry_q) && $stable(digit_carry_flag_q)))
        else $error("bit set wrong");

    a_port_operand: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (port_hit[0]) |-> (operand == pins_sync_q[7:0]))
        else $error("port operand not from pins");

    // expectation rebuilt from the raw instruction fields, not from the write strobe
    a_prescale_clr: assert property (@(posedge sys_clk) disable iff (!rst_b)
        prescale_clr == (instr_valid && prescale_to_timer &&
                         instr[fraops_pkg::ADDR_W-1:0] == TIMER_ZERO_ADDR &&
                         (instr[fraops_pkg::BITOP_HI:fraops_pkg::BITOP_LO] == fraops_pkg::OPC_BIT_CLEAR_FILE ||
                          instr[fraops_pkg::BITOP_HI:fraops_pkg::BITOP_LO] == fraops_pkg::OPC_BIT_SET_FILE ||
                          (instr[fraops_pkg::DEST_POS] &&
                           (instr[fraops_pkg::OPC_HI:fraops_pkg::OPC_LO] == fraops_pkg::OPC_ADD_WORK_TO_FILE ||
                            instr[fraops_pkg::OPC_HI:fraops_pkg::OPC_LO] == fraops_pkg::OPC_AND_WORK_WITH_FILE)))))
        else $error("prescaler clear wrong");

    a_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (file_we |-> instr_valid) and (instr_done == instr_valid))
        else $error("instruction not single cycle");
endmodule

// *** dv/fraops_tb.sv ***
module fraops_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk;
    logic        rst_b;
    logic        instr_valid;
    logic [13:0] instr;
    logic [7:0]  file_rdata;
    logic [15:0] port_pins;
    logic        prescale_to_timer;
    logic [6:0]  file_addr;
    logic        file_we;
    logic [7:0]  file_wdata;
    logic [7:0]  work_q;
    logic        carry_q;
    logic        digit_carry_flag_q;
    logic        zero_q;
    logic        prescale_clr;
    logic        instr_done;
    logic [7:0]  w_e;
    logic        c_e;
    logic        dc_e;
    logic        z_e;
    int          fails;
    int          compares;
    int          cycles;
    localparam logic [5:0] ADD = fraops_pkg::OPC_ADD_WORK_TO_FILE;
    localparam logic [5:0] AND = fraops_pkg::OPC_AND_WORK_WITH_FILE;
    localparam logic [3:0] CLR = fraops_pkg::OPC_BIT_CLEAR_FILE;
    localparam logic [3:0] SET = fraops_pkg::OPC_BIT_SET_FILE;

    fraops_core u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
        .file_rdata(file_rdata), .port_pins(port_pins), .prescale_to_timer(prescale_to_timer),
        .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata), .work_q(work_q),
        .carry_q(carry_q), .digit_carry_flag_q(digit_carry_flag_q), .zero_q(zero_q),
        .prescale_clr(prescale_clr), .instr_done(instr_done));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic results();
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one instruction: fv is what the file returns, opnd the operand the core must really use
    task automatic step(input logic [13:0] iw, input logic v, input logic [7:0] fv, input logic [7:0] opnd);
        logic [8:0] sum;
        logic [4:0] lo;
        logic [7:0] res;
        logic [7:0] nw;
        logic       nc;
        logic       ndc;
        logic       nz;
        logic       we;
        logic       byte_op;
        sum = {1'b0, w_e} + {1'b0, opnd};
        lo = {1'b0, w_e[3:0]} + {1'b0, opnd[3:0]};
        nw = w_e;
        nc = c_e;
        ndc = dc_e;
        nz = z_e;
        res = opnd;
        we = 1'b0;
        byte_op = v && (iw[13:8] == ADD || iw[13:8] == AND);
        if (v && iw[13:8] == ADD) begin
            res = sum[7:0];
            nc = sum[8];
            ndc = lo[4];
        end else if (v && iw[13:8] == AND) res = w_e & opnd;
        else if (v && iw[13:10] == CLR) begin
            res[iw[9:7]] = 1'b0;
            we = 1'b1;
        end else if (v && iw[13:10] == SET) begin
            res[iw[9:7]] = 1'b1;
            we = 1'b1;
        end
        if (byte_op) begin
            nz = (res == 8'h00);
            we = iw[7];
            if (!iw[7]) nw = res;
        end
        @(posedge sys_clk);
        instr <= iw;
        instr_valid <= v;
        file_rdata <= fv;
        @(negedge sys_clk);
        chk1("file_we", we, file_we);
        chk1("instr_done", v, instr_done);
        chk8("file_addr", {1'b0, iw[6:0]}, {1'b0, file_addr});
        if (we) chk8("file_wdata", res, file_wdata);
        chk1("prescale_clr", we && prescale_to_timer && iw[6:0] == 7'h01, prescale_clr);
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        @(negedge sys_clk);
        chk8("work_q", nw, work_q);
        chk1("carry_q", nc, carry_q);
        chk1("digit_carry_flag_q", ndc, digit_carry_flag_q);
        chk1("zero_q", nz, zero_q);
        w_e = nw;
        c_e = nc;
        dc_e = ndc;
        z_e = nz;
    endtask

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles >= 3000) begin
            fails++;
            results();
        end
    end

    initial begin
        {fails, compares, cycles} = '0;
        {rst_b, instr_valid, instr, file_rdata, port_pins, prescale_to_timer} = '0;
        {w_e, c_e, dc_e, z_e} = '0;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(negedge sys_clk);
        chk8("work_q", 8'h00, work_q);
        chk1("zero_q", 1'b0, zero_q);
        step({ADD, 8'h10}, 1'b1, 8'h17, 8'h17);
        step({ADD, 8'h04}, 1'b1, 8'hc2, 8'hc2);
        step({ADD, 8'h84}, 1'b1, 8'h27, 8'h27);
        step({AND, 8'h84}, 1'b1, 8'hc2, 8'hc2);
        step({AND, 8'h7f}, 1'b1, 8'h26, 8'h26);
        step({ADD, 8'h7f}, 1'b1, 8'h0f, 8'h0f);
        for (int b = 0; b < 8; b++) begin
            step({SET, b[2:0], 7'h7f}, 1'b1, 8'h0a, 8'h0a);
            step({CLR, b[2:0], 7'h00}, 1'b1, 8'hc7, 8'hc7);
        end
        step(14'h0290, 1'b1, 8'h55, 8'h55);
        step({ADD, 8'h90}, 1'b0, 8'h55, 8'h55);
        @(posedge sys_clk);
        prescale_to_timer <= 1'b1;
        step({ADD, 8'h81}, 1'b1, 8'h33, 8'h33);
        step({AND, 8'h01}, 1'b1, 8'h33, 8'h33);
        step({SET, 3'h2, 7'h01}, 1'b1, 8'h00, 8'h00);
        @(posedge sys_clk);
        prescale_to_timer <= 1'b0;
        step({CLR, 3'h0, 7'h01}, 1'b1, 8'hff, 8'hff);
        // pins differ from the latch byte so a latch read shows up
        @(posedge sys_clk);
        port_pins <= 16'h3c5a;
        repeat (3) @(posedge sys_clk);
        step({ADD, 8'h85}, 1'b1, 8'hff, 8'h5a);
        step({SET, 3'h7, 7'h06}, 1'b1, 8'h00, 8'h3c);
        step({AND, 8'h05}, 1'b1, 8'h00, 8'h5a);
        // mid-run reset must clear the working register, carry and zero flags at once
        @(posedge sys_clk);
        rst_b <= 1'b0;
        @(negedge sys_clk);
        chk8("work_q", 8'h00, work_q);
        chk1("carry_q", 1'b0, carry_q);
        chk1("zero_q", 1'b0, zero_q);
        @(posedge sys_clk);
        rst_b <= 1'b1;
        @(negedge sys_clk);
        chk8("work_q", 8'h00, work_q);
        results();
    end
endmodule
